//--- include/rre_pkg.sv
// shared constants and types for the return and rotate execution block
package rre_pkg;
  // instruction word layout
  localparam int unsigned RRE_WORD_W = 14;
  localparam int unsigned RRE_OP_MSB = 13;
  localparam int unsigned RRE_OP_LSB = 8;
  localparam int unsigned RRE_DEST_BIT = 7;
  localparam int unsigned RRE_ADDR_W = 7;
  localparam int unsigned RRE_DATA_W = 8;
  // opcode field values of the four handled instructions
  localparam logic [5:0] RRE_OP_IRET = 6'h01;
  localparam logic [5:0] RRE_OP_RET = 6'h02;
  localparam logic [5:0] RRE_OP_LITRET = 6'h03;
  localparam logic [5:0] RRE_OP_ROTL = 6'h04;
  // destination select of the rotate
  localparam logic RRE_DEST_ACCUM = 1'b0;
  localparam logic RRE_DEST_REG = 1'b1;
  // bit of the interrupt control register that enables interrupts
  localparam int unsigned RRE_GIE_BIT = 7;
  // reset values
  localparam logic [7:0] RRE_ACCUM_RST = 8'h00;
  localparam logic RRE_CARRY_RST = 1'b0;
  localparam logic RRE_GIE_RST = 1'b0;

  typedef enum logic [0:0] {
    RRE_IDLE,
    RRE_FLUSH
  } rre_state_t;
endpackage

//--- include/rre_rot_if.sv
// operand and result carrier between the executor and its rotator
`timescale 1ns/1ps
`default_nettype none
interface rre_rot_if;
  logic [7:0] src;
  logic carry_in;
  logic [7:0] result;
  logic carry_out;
  modport exec (output src, output carry_in, input result, input carry_out);
  modport rot (input src, input carry_in, output result, output carry_out);
endinterface // rre_rot_if
`default_nettype wire

//--- logic/rre_rotate.sv
// left rotate of one data byte through the carry flag
`timescale 1ns/1ps
`default_nettype none
module rre_rotate
  import rre_pkg::*;
(
  rre_rot_if.rot rot
);
  // old carry enters bit 0, old bit 7 leaves as the new carry
  assign rot.result = {rot.src[6:0], rot.carry_in};
  assign rot.carry_out = rot.src[7];
endmodule // rre_rotate
`default_nettype wire

//--- logic/rre_exec.sv
// execution logic for the three returns and the rotate left through carry
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - interrupt return pops the stack and loads its top entry into the pc.
// - interrupt return sets the global interrupt enable, touches no other flag.
// - interrupt return is one word and takes two instruction cycles.
// - literal return writes its 8-bit literal into the accumulator.
// - literal return loads pc from stack top; two cycles; no flags changed.
// - plain return pops stack into pc; two cycles; flags and enable unchanged.
// - rotate left: old carry into bit 0, old bit 7 into carry.
// - destination 0 writes accumulator, destination 1 writes the source register.
// - rotate addresses registers 0 to 127, changes only carry, one cycle.
module rre_exec
  import rre_pkg::*;
#(
  parameter int unsigned PC_W = 15
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // instruction from fetch, with the addressed register's value
  input wire logic i_instr_valid,
  input wire logic [RRE_WORD_W-1:0] i_instr_word,
  input wire logic [RRE_DATA_W-1:0] i_src_data,
  // hardware stack top and interrupt entry
  input wire logic [PC_W-1:0] i_tos,
  input wire logic i_gie_clear,
  // handshake and pipeline control
  output logic o_ready,
  output logic o_flush,
  // stack and program counter
  output logic o_stack_pop,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_value,
  // register file write port
  output logic o_rf_we,
  output logic [RRE_ADDR_W-1:0] o_rf_addr,
  output logic [RRE_DATA_W-1:0] o_rf_wdata,
  // core state held here
  output logic [RRE_DATA_W-1:0] o_accum,
  output logic o_carry,
  output logic o_gie
);
  // refuse a program counter width below 1 or above 32
  if (PC_W < 1 || PC_W > 32) begin : g_chk
    $error("rre_exec: PC_W out of range");
  end

  typedef struct packed {
    rre_state_t state;
    logic ready;
    logic flush;
    logic pop;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic rf_we;
    logic [RRE_ADDR_W-1:0] rf_addr;
    logic [RRE_DATA_W-1:0] rf_wdata;
    logic [RRE_DATA_W-1:0] accum;
    logic carry;
    logic global_int_enable;
  } rre_regs_t;

  rre_regs_t r_q;
  rre_regs_t r_d;
  rre_rot_if rot_if ();
  logic take;
  logic [5:0] opcode;
  logic dest_sel;

  // decode fields of the presented word
  assign take = i_instr_valid && r_q.ready;
  assign opcode = i_instr_word[RRE_OP_MSB:RRE_OP_LSB];
  assign dest_sel = i_instr_word[RRE_DEST_BIT];
  assign rot_if.src = i_src_data;
  assign rot_if.carry_in = r_q.carry;

  rre_rotate u_rot (
    .rot(rot_if.rot)
  );

  // next state; pulses default low every cycle
  always_comb begin
    r_d = r_q;
    r_d.pop = 1'b0;
    r_d.pc_load = 1'b0;
    r_d.rf_we = 1'b0;
    r_d.flush = 1'b0;
    r_d.ready = 1'b1;
    r_d.state = RRE_IDLE;
    // interrupt entry clears the enable; a same-cycle return-set wins below
    if (i_gie_clear) begin
      r_d.global_int_enable = 1'b0;
    end
    unique case (r_q.state)
      RRE_IDLE: begin
        if (take) begin
          unique case (opcode)
            RRE_OP_IRET: begin
              r_d.pop = 1'b1;
              r_d.pc_load = 1'b1;
              r_d.pc_value = i_tos;
              r_d.global_int_enable = 1'b1;
              r_d.state = RRE_FLUSH;
              r_d.ready = 1'b0;
              r_d.flush = 1'b1;
            end
            RRE_OP_LITRET: begin
              r_d.accum = i_instr_word[RRE_DATA_W-1:0];
              r_d.pop = 1'b1;
              r_d.pc_load = 1'b1;
              r_d.pc_value = i_tos;
              r_d.state = RRE_FLUSH;
              r_d.ready = 1'b0;
              r_d.flush = 1'b1;
            end
            RRE_OP_RET: begin
              r_d.pop = 1'b1;
              r_d.pc_load = 1'b1;
              r_d.pc_value = i_tos;
              r_d.state = RRE_FLUSH;
              r_d.ready = 1'b0;
              r_d.flush = 1'b1;
            end
            RRE_OP_ROTL: begin
              // only the carry flag moves; finishes in this one cycle
              r_d.carry = rot_if.carry_out;
              if (dest_sel == RRE_DEST_ACCUM) begin
                r_d.accum = rot_if.result;
              end else begin
                r_d.rf_we = 1'b1;
                r_d.rf_addr = i_instr_word[RRE_ADDR_W-1:0];
                r_d.rf_wdata = rot_if.result;
              end
            end
            default: begin
              // other opcodes belong to the rest of the core
            end
          endcase
        end
      end
      RRE_FLUSH: begin
        // prefetched word is dropped; only an interrupt entry can still clear the enable this cycle
        r_d.ready = 1'b1;
      end
    endcase
  end

  // single state register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      r_q <= '{state: RRE_IDLE, ready: 1'b1, flush: 1'b0, pop: 1'b0, pc_load: 1'b0,
               pc_value: '0, rf_we: 1'b0, rf_addr: '0, rf_wdata: '0,
               accum: RRE_ACCUM_RST, carry: RRE_CARRY_RST, global_int_enable: RRE_GIE_RST};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state register
  assign o_ready = r_q.ready;
  assign o_flush = r_q.flush;
  assign o_stack_pop = r_q.pop;
  assign o_pc_load = r_q.pc_load;
  assign o_pc_value = r_q.pc_value;
  assign o_rf_we = r_q.rf_we;
  assign o_rf_addr = r_q.rf_addr;
  assign o_rf_wdata = r_q.rf_wdata;
  assign o_accum = r_q.accum;
  assign o_carry = r_q.carry;
  assign o_gie = r_q.global_int_enable;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  logic take_iret;
  logic take_lit;
  logic take_ret;
  logic take_rot;
  assign take_iret = take && opcode == RRE_OP_IRET;
  assign take_lit = take && opcode == RRE_OP_LITRET;
  assign take_ret = take && opcode == RRE_OP_RET;
  assign take_rot = take && opcode == RRE_OP_ROTL;

  a_pop_loads_pc: assert property (take_iret |=> o_stack_pop && o_pc_load && o_pc_value == $past(i_tos))
    else $error("interrupt return did not pop into pc");
  a_iret_sets_gie: assert property (take_iret |=> o_gie && o_carry == $past(o_carry))
    else $error("interrupt return flag effect wrong");
  a_iret_two_cyc: assert property (take_iret |=> !o_ready ##1 (o_ready && !o_stack_pop))
    else $error("interrupt return not two cycles");
  a_lit_to_accum: assert property (take_lit |=> o_accum == $past(i_instr_word[7:0]))
    else $error("literal not in accumulator");
  a_lit_no_flags: assert property (take_lit && !i_gie_clear |=> o_pc_load && !o_ready
                                   && o_carry == $past(o_carry) && o_gie == $past(o_gie))
    else $error("literal return wrong");
  a_ret_no_flags: assert property (take_ret && !i_gie_clear |=> o_stack_pop && $stable(o_gie)
                                   && $stable(o_carry) && $stable(o_accum) ##1 o_ready)
    else $error("return changed state");
  a_rot_value: assert property (take_rot && dest_sel |=> o_rf_we && o_carry == $past(i_src_data[7])
                                && o_rf_wdata == {$past(i_src_data[6:0]), $past(o_carry)})
    else $error("rotate result wrong");
  a_rot_dest_acc: assert property (take_rot && !dest_sel |=> !o_rf_we
                                   && o_accum == {$past(i_src_data[6:0]), $past(o_carry)})
    else $error("rotate destination wrong");
  // interrupt entry may clear the enable in the same edge, so leave that case out
  a_rot_one_cyc: assert property (take_rot && !i_gie_clear |=> o_ready && !o_stack_pop && $stable(o_gie)
                                  && (!o_rf_we || o_rf_addr == $past(i_instr_word[6:0])))
    else $error("rotate timing or address wrong");
  a_flush_noop: assert property (o_flush |-> !o_ready ##1 (!o_flush && !o_rf_we && !o_stack_pop))
    else $error("flush cycle not a no-operation");

  c_iret: cover property (take_iret ##2 take);
  c_lit: cover property (take_lit);
  c_rot_reg: cover property (take_rot && dest_sel ##1 take_rot && !dest_sel);
  c_gie_race: cover property (take_iret && i_gie_clear);
endmodule // rre_exec
`default_nettype wire

//--- bench/rre_partner.sv
// return stack and data register file model facing the executor
`timescale 1ns/1ps
`default_nettype none
module rre_partner
  import rre_pkg::*;
#(
  parameter int unsigned PC_W = 15
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // stack loading by the bench and popping by the executor
  input wire logic i_push,
  input wire logic [PC_W-1:0] i_push_val,
  input wire logic i_stack_pop,
  // register file read and write
  input wire logic [RRE_ADDR_W-1:0] i_rd_addr,
  input wire logic i_rf_we,
  input wire logic [RRE_ADDR_W-1:0] i_rf_addr,
  input wire logic [RRE_DATA_W-1:0] i_rf_wdata,
  // answers
  output logic [PC_W-1:0] o_tos,
  output logic [RRE_DATA_W-1:0] o_src_data
);
  logic [PC_W-1:0] stk_q [0:15];
  logic [4:0] sp_q;
  logic [RRE_DATA_W-1:0] mem_q [0:127];

  // stack pointer moves on push or pop; register file starts from a fixed pattern
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sp_q <= 5'h00;
      for (int i = 0; i < 128; i++) mem_q[i] <= 8'(i * 37 + 5);
    end else begin
      if (i_push) begin
        stk_q[sp_q[3:0]] <= i_push_val;
        sp_q <= sp_q + 5'h01;
      end else if (i_stack_pop && sp_q != 5'h00) begin
        sp_q <= sp_q - 5'h01;
      end
      if (i_rf_we) mem_q[i_rf_addr] <= i_rf_wdata;
    end
  end

  // an empty stack shows inverted data so a stale entry never looks right
  assign o_tos = (sp_q == 5'h00) ? ~stk_q[0] : stk_q[sp_q[3:0] - 4'h1];
  assign o_src_data = mem_q[i_rd_addr];
endmodule // rre_partner
`default_nettype wire

//--- bench/return_and_rotate_exec_bench.sv
// self-checking bench for the return and rotate executor
`timescale 1ns/1ps
`default_nettype none
module return_and_rotate_exec_bench;
  import rre_pkg::*;
  logic clk = 1'b0, rst = 1'b1, valid = 1'b0, gie_clr = 1'b0, push = 1'b0;
  logic [13:0] word = 14'h0000;
  logic [14:0] push_val = 15'h0000, top_of_stack_entry, pc_value;
  logic [7:0] src, accum, rf_wdata;
  logic [6:0] rf_addr;
  logic ready, flush, pop, pc_load, rf_we, carry, global_int_enable;
  int err_count = 0, tests_run = 0;
  logic [7:0] mirror [0:127];

  always #12.5 clk = ~clk;

  rre_exec #(.PC_W(15)) dut (.i_core_clk(clk), .i_rst(rst), .i_instr_valid(valid), .i_instr_word(word),
    .i_src_data(src), .i_tos(top_of_stack_entry), .i_gie_clear(gie_clr), .o_ready(ready), .o_flush(flush),
    .o_stack_pop(pop), .o_pc_load(pc_load), .o_pc_value(pc_value), .o_rf_we(rf_we), .o_rf_addr(rf_addr),
    .o_rf_wdata(rf_wdata), .o_accum(accum), .o_carry(carry), .o_gie(global_int_enable));
  rre_partner #(.PC_W(15)) far (.i_core_clk(clk), .i_rst(rst), .i_push(push), .i_push_val(push_val),
    .i_stack_pop(pop), .i_rd_addr(word[6:0]), .i_rf_we(rf_we), .i_rf_addr(rf_addr), .i_rf_wdata(rf_wdata),
    .o_tos(top_of_stack_entry), .o_src_data(src));

  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask

  // present one word; returns just after the edge that takes it
  task automatic issue(logic [5:0] op, logic [7:0] arg);
    @(posedge clk);
    valid <= 1'b1;
    word <= {op, arg};
    @(posedge clk);
    valid <= 1'b0;
    #1;
  endtask

  task automatic do_return(logic [5:0] op, logic [7:0] k, logic [14:0] ret_addr);
    logic [7:0] acc0;
    logic c0, g0;
    @(posedge clk);
    push <= 1'b1;
    push_val <= ret_addr;
    @(posedge clk);
    push <= 1'b0;
    #1;
    acc0 = accum;
    c0 = carry;
    g0 = global_int_enable;
    issue(op, k);
    chk("stack pop", 16'h1, {15'h0, pop});
    chk("pc load", 16'h1, {15'h0, pc_load});
    chk("pc value", {1'b0, ret_addr}, {1'b0, pc_value});
    chk("flush", 16'h1, {15'h0, flush});
    chk("ready second cycle", 16'h0, {15'h0, ready});
    chk("gie", {15'h0, (op == RRE_OP_IRET) ? 1'b1 : g0}, {15'h0, global_int_enable});
    chk("accum", {8'h0, (op == RRE_OP_LITRET) ? k : acc0}, {8'h0, accum});
    chk("carry", {15'h0, c0}, {15'h0, carry});
    @(posedge clk);
    #1;
    chk("ready after", 16'h1, {15'h0, ready});
    chk("pulses after", 16'h0, {13'h0, pop, pc_load, flush});
  endtask

  task automatic do_rotate(logic dest, logic [6:0] addr);
    logic [8:0] r;
    logic [7:0] acc0;
    logic g0;
    r = {mirror[addr], carry};
    acc0 = accum;
    g0 = global_int_enable;
    issue(RRE_OP_ROTL, {dest, addr});
    chk("rot carry", {15'h0, r[8]}, {15'h0, carry});
    chk("rot accum", {8'h0, dest ? acc0 : r[7:0]}, {8'h0, accum});
    chk("rot write", {15'h0, dest}, {15'h0, rf_we});
    if (dest) chk("rot addr data", {1'b0, addr, r[7:0]}, {1'b0, rf_addr, rf_wdata});
    chk("rot one cycle", 16'h3, {14'h0, ready, ~pop});
    chk("rot gie", {15'h0, g0}, {15'h0, global_int_enable});
    if (dest) mirror[addr] = r[7:0];
  endtask

  // interrupt entry in the very edge that takes an interrupt return: the set wins
  task automatic do_race(logic [14:0] ret_addr);
    @(posedge clk);
    push <= 1'b1;
    push_val <= ret_addr;
    @(posedge clk);
    push <= 1'b0;
    valid <= 1'b1;
    word <= {RRE_OP_IRET, 8'h00};
    gie_clr <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    gie_clr <= 1'b0;
    #1;
    chk("race gie", 16'h1, {15'h0, global_int_enable});
    chk("race pc value", {1'b0, ret_addr}, {1'b0, pc_value});
    @(posedge clk);
    #1;
    chk("race ready", 16'h1, {15'h0, ready});
  endtask

  // an opcode outside the four is taken in one cycle and changes nothing here
  task automatic do_unknown(logic [7:0] arg);
    logic [7:0] acc0;
    logic c0, g0;
    acc0 = accum;
    c0 = carry;
    g0 = global_int_enable;
    issue(6'h3f, arg);
    chk("unknown pulses", 16'h0, {12'h0, pop, pc_load, flush, rf_we});
    chk("unknown state", {6'h0, 1'b1, acc0, c0}, {6'h0, ready, accum, carry});
    chk("unknown gie", {15'h0, g0}, {15'h0, global_int_enable});
  endtask

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // watchdog sized well above the fewer than 100 cycles the tests need
  initial begin
    #75000;
    err_count++;
    complete_run();
  end

  initial begin
    logic [7:0] tbl [0:7];
    tbl = '{8'h00, 8'h80, 8'h00, 8'hff, 8'h7f, 8'h04, 8'h04, 8'h40};
    for (int i = 0; i < 128; i++) mirror[i] = 8'(i * 37 + 5);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset state", 16'h8000, {ready, accum, carry, global_int_enable, 4'h0, pc_value[0]});
    do_return(RRE_OP_IRET, 8'h00, 15'h1234);
    @(posedge clk);
    gie_clr <= 1'b1;
    @(posedge clk);
    gie_clr <= 1'b0;
    #1;
    chk("gie cleared", 16'h0, {15'h0, global_int_enable});
    do_race(15'h0c3a);
    do_return(RRE_OP_RET, 8'h5a, 15'h7fff);
    do_return(RRE_OP_LITRET, 8'hff, 15'h0001);
    do_return(RRE_OP_LITRET, 8'h00, 15'h4000);
    do_return(RRE_OP_IRET, 8'h3c, 15'h2aaa);
    do_return(RRE_OP_RET, 8'h00, 15'h0155);
    // follow each register write-back with a rotate of that register so it is read again
    for (int i = 0; i < 8; i++) do_rotate(tbl[i][7], tbl[i][6:0]);
    do_rotate(1'b1, 7'h7f);
    do_rotate(1'b0, 7'h7f);
    do_unknown(8'hff);
    complete_run();
  end
endmodule // return_and_rotate_exec_bench
`default_nettype wire
